// ### rtl/dam_monitor.sv
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/10ps
// Functional notes
// - History store keeps at most 64 events
// - Events enter history in occurrence order
// - Each alarm has state and occurrence count
// - Clear empties history and zeroes counters
// - Alarm when count strictly exceeds threshold
// - 15-minute thresholds 0..900, zero disables
// - 1-day thresholds 0..86400, default zero
// - Margin threshold 0..15, zero disables
// - Attenuation threshold 0..127, zero disables
// - Keep 96 past 15-minute interval records
// - Threshold changes only on commit, abandon keeps
// - State report covers every alarm type
module dam_monitor #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire dam_pkg::dam_req_type req,
  output logic [dam_pkg::DATA_W-1:0] rdata,
  input wire dam_pkg::dam_pm_type pm,
  input wire dam_pkg::dam_line_type line_raw,
  input wire logic interval_end,
  input wire logic [dam_pkg::STAMP_W-1:0] stamp,
  output logic irq
);
  import dam_pkg::*;

  typedef struct packed {
    dam_line_type line_meta;
    dam_line_type line_sync;
    logic [PM_KINDS-1:0][TH15_W-1:0] th15;
    logic [PM_KINDS-1:0][THDAY_W-1:0] thday;
    logic [SNR_W-1:0] th_snr;
    logic [ATTN_W-1:0] th_attn;
    logic [EDIT_W-1:0] edit;
    logic [ALARM_NUM-1:0] alarm;
    logic [ALARM_NUM-1:0] logged;
    logic [ALARM_NUM-1:0][CNT_W-1:0] cnt;
    logic [ALARM_IDX_W-1:0] cnt_sel;
    logic [HIST_PTR_W-1:0] hist_sel;
    logic [PMH_PTR_W-1:0] pmh_sel;
    logic [PMH_PTR_W-1:0] pmh_wp;
    logic [PMH_PTR_W-1:0] pmh_cnt;
    logic [PMH_DEPTH-1:0][PMH_ENT_W-1:0] pmh;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic irq;
    logic [DATA_W-1:0] rdata;
  } dam_mon_state_type;

  dam_mon_state_type s_q;
  dam_mon_state_type s_d;
  logic [ALARM_NUM-1:0] rise;
  logic [ALARM_NUM-1:0] fall;
  logic clr_cmd;
  logic commit_wr;
  logic hist_push;
  logic hist_wrap;
  dam_hist_ent_type hist_ent;
  dam_hist_ent_type hist_rd;
  logic [HIST_CNT_W-1:0] hist_count;

  function automatic logic hit(input logic en, input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    return en && (a == off);
  endfunction

  // Lowest pending index first, so a burst drains in a fixed order
  function automatic logic [ALARM_IDX_W-1:0] first_set(input logic [ALARM_NUM-1:0] v);
    logic [ALARM_IDX_W-1:0] r;
    r = '0;
    for (int i = ALARM_NUM - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = ALARM_IDX_W'(i);
      end
    end
    return r;
  endfunction

  // Out-of-range commits are dropped so a stored threshold is always legal
  function automatic logic in_range(input logic [COMMIT_TGT_W-1:0] t,
                                    input logic [EDIT_W-1:0] v);
    logic ok;
    ok = 1'b0;
    case (t)
      TGT_15_UAS, TGT_15_SES, TGT_15_ES: ok = (v <= EDIT_W'(TH15_MAX));
      TGT_DAY_UAS, TGT_DAY_SES, TGT_DAY_ES: ok = (v <= THDAY_MAX);
      TGT_SNR: ok = (v <= EDIT_W'({SNR_W{1'b1}}));
      TGT_ATTN: ok = (v <= EDIT_W'({ATTN_W{1'b1}}));
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Bus strobes decoded once for the command side effects
  assign clr_cmd = hit(req.wr, req.addr, REG_CTRL) && req.wdata[CTRL_CLEAR_BIT];
  assign commit_wr = hit(req.wr, req.addr, REG_COMMIT);

  always_comb begin
    logic [ALARM_NUM-1:0] cond;
    logic [ALARM_NUM-1:0] pending;
    logic [ALARM_IDX_W-1:0] ev_idx;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr_mask;
    logic [COMMIT_TGT_W-1:0] tgt;
    logic [PMH_PTR_W:0] pos;
    cond = '0;
    pending = '0;
    ev_idx = '0;
    ev = '0;
    clr_mask = '0;
    tgt = req.wdata[COMMIT_TGT_W-1:0];
    pos = '0;
    s_d = s_q;

    // Loss levels come from pins: two flops before use
    s_d.line_meta = line_raw;
    s_d.line_sync = s_q.line_meta;

    // Alarm conditions from the synchronised levels and the counts
    cond[ALM_LINE_LOSS] = s_q.line_sync.line_signal_loss_alarm;
    cond[ALM_SYNC_LOSS] = s_q.line_sync.line_sync_word_loss_alarm;
    cond[ALM_TERM_LOSS] = s_q.line_sync.terminal_port_signal_loss_alarm;
    cond[ALM_MARGIN] = (s_q.th_snr != '0) && (pm.margin < MEAS_W'(s_q.th_snr));
    cond[ALM_ATTN] = (s_q.th_attn != '0) && (pm.attenuation > MEAS_W'(s_q.th_attn));
    for (int k = 0; k < PM_KINDS; k++) begin
      cond[ALM_15_BASE + k] = (s_q.th15[k] != '0) && (pm.cur15[k] > s_q.th15[k]);
      cond[ALM_DAY_BASE + k] = pm.day[k] > s_q.thday[k];
    end
    s_d.alarm = cond;
    rise = cond & ~s_q.alarm;
    fall = ~cond & s_q.alarm;

    // Occurrence counters; a raise in the clear cycle still counts once
    for (int i = 0; i < ALARM_NUM; i++) begin
      if (rise[i]) begin
        s_d.cnt[i] = clr_cmd ? CNT_W'(1) : s_q.cnt[i] + CNT_W'(1);
      end else if (clr_cmd) begin
        s_d.cnt[i] = '0;
      end
    end

    // One history event per cycle keeps simultaneous changes ordered
    pending = s_q.alarm ^ s_q.logged;
    hist_push = |pending;
    ev_idx = first_set(pending);
    s_d.logged[ev_idx] = s_q.alarm[ev_idx];
    hist_ent.alarm = ev_idx;
    hist_ent.raised = s_q.alarm[ev_idx];
    hist_ent.stamp = stamp;

    // Interval history ring, newest overwrites the oldest after 96
    if (interval_end) begin
      s_d.pmh[s_q.pmh_wp] = s_q.pmh[s_q.pmh_wp];
      s_d.pmh[s_q.pmh_wp] = pm.cur15;
      s_d.pmh_wp = (s_q.pmh_wp == PMH_LAST) ? '0 : s_q.pmh_wp + PMH_PTR_W'(1);
      if (s_q.pmh_cnt != PMH_FULL) begin
        s_d.pmh_cnt = s_q.pmh_cnt + PMH_PTR_W'(1);
      end
    end

    // Register writes
    if (req.wr) begin
      case (req.addr)
        REG_EDIT: s_d.edit = req.wdata[EDIT_W-1:0];
        REG_COMMIT: begin
          if (req.wdata[COMMIT_ABANDON_BIT]) begin
            s_d.edit = '0;
          end else if (in_range(tgt, s_q.edit)) begin
            case (tgt)
              TGT_15_UAS: s_d.th15[PM_UAS] = s_q.edit[TH15_W-1:0];
              TGT_15_SES: s_d.th15[PM_SES] = s_q.edit[TH15_W-1:0];
              TGT_15_ES: s_d.th15[PM_ES] = s_q.edit[TH15_W-1:0];
              TGT_DAY_UAS: s_d.thday[PM_UAS] = s_q.edit[THDAY_W-1:0];
              TGT_DAY_SES: s_d.thday[PM_SES] = s_q.edit[THDAY_W-1:0];
              TGT_DAY_ES: s_d.thday[PM_ES] = s_q.edit[THDAY_W-1:0];
              TGT_SNR: s_d.th_snr = s_q.edit[SNR_W-1:0];
              TGT_ATTN: s_d.th_attn = s_q.edit[ATTN_W-1:0];
              default: s_d.edit = s_q.edit;
            endcase
          end
        end
        REG_CNT_SEL: s_d.cnt_sel = req.wdata[ALARM_IDX_W-1:0];
        REG_HIST_SEL: s_d.hist_sel = req.wdata[HIST_PTR_W-1:0];
        REG_PMH_SEL: s_d.pmh_sel = req.wdata[PMH_PTR_W-1:0];
        REG_IRQ_EN: s_d.irq_en = req.wdata[IRQ_W-1:0];
        REG_IRQ_CLR: clr_mask = req.wdata[IRQ_W-1:0];
        default: s_d.edit = s_d.edit;
      endcase
    end

    // Sticky events; a new event beats a clear in the same cycle
    ev[IRQ_RAISE] = |rise;
    ev[IRQ_FALL] = |fall;
    ev[IRQ_WRAP] = hist_wrap;
    ev[IRQ_INTERVAL] = interval_end;
    s_d.irq_stat = (s_q.irq_stat & ~clr_mask) | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_en);

    // Read data stands only in the cycle after the strobe
    s_d.rdata = '0;
    if (req.rd) begin
      case (req.addr)
        REG_TH15_UAS: s_d.rdata = DATA_W'(s_q.th15[PM_UAS]);
        REG_TH15_SES: s_d.rdata = DATA_W'(s_q.th15[PM_SES]);
        REG_TH15_ES: s_d.rdata = DATA_W'(s_q.th15[PM_ES]);
        REG_THDAY_UAS: s_d.rdata = DATA_W'(s_q.thday[PM_UAS]);
        REG_THDAY_SES: s_d.rdata = DATA_W'(s_q.thday[PM_SES]);
        REG_THDAY_ES: s_d.rdata = DATA_W'(s_q.thday[PM_ES]);
        REG_TH_SNR: s_d.rdata = DATA_W'(s_q.th_snr);
        REG_TH_ATTN: s_d.rdata = DATA_W'(s_q.th_attn);
        REG_EDIT: s_d.rdata = DATA_W'(s_q.edit);
        REG_STATE: s_d.rdata = DATA_W'(s_q.alarm);
        REG_CNT_SEL: s_d.rdata = DATA_W'(s_q.cnt_sel);
        REG_CNT_DATA: begin
          if (s_q.cnt_sel < ALARM_IDX_W'(ALARM_NUM)) begin
            s_d.rdata = DATA_W'(s_q.cnt[s_q.cnt_sel]);
          end
        end
        REG_HIST_SEL: s_d.rdata = DATA_W'(s_q.hist_sel);
        REG_HIST_INFO: begin
          s_d.rdata[ALARM_IDX_W-1:0] = hist_rd.alarm;
          s_d.rdata[HIST_RAISED_BIT] = hist_rd.raised;
        end
        REG_HIST_STAMP: s_d.rdata = hist_rd.stamp;
        REG_HIST_COUNT: s_d.rdata = DATA_W'(hist_count);
        REG_IRQ_STAT: s_d.rdata = DATA_W'(s_q.irq_stat);
        REG_IRQ_EN: s_d.rdata = DATA_W'(s_q.irq_en);
        REG_PMH_SEL: s_d.rdata = DATA_W'(s_q.pmh_sel);
        REG_PMH_DATA: begin
          // Index 0 is the most recent finished interval
          if (s_q.pmh_sel < s_q.pmh_cnt) begin
            pos = {1'b0, s_q.pmh_wp} + (PMH_PTR_W + 1)'(PMH_DEPTH - 1) - {1'b0, s_q.pmh_sel};
            if (pos >= (PMH_PTR_W + 1)'(PMH_DEPTH)) begin
              pos = pos - (PMH_PTR_W + 1)'(PMH_DEPTH);
            end
            s_d.rdata = DATA_W'(s_q.pmh[pos[PMH_PTR_W-1:0]]);
          end
        end
        REG_PMH_COUNT: s_d.rdata = DATA_W'(s_q.pmh_cnt);
        default: s_d.rdata = '0;
      endcase
    end
  end

  // Single register stage for the whole block
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.th15 <= {PM_KINDS{TH_RESET[TH15_W-1:0]}};
      s_q.thday <= {PM_KINDS{TH_RESET}};
    end else begin
      s_q <= s_d;
    end
  end

  dam_history u_hist (
    .sys_clk(sys_clk),
    .srst(srst),
    .push(hist_push),
    .ent(hist_ent),
    .clear(clr_cmd),
    .rd_idx(s_q.hist_sel),
    .rd_ent(hist_rd),
    .count(hist_count),
    .wrap(hist_wrap)
  );

  assign rdata = s_q.rdata;
  assign irq = s_q.irq;

  chk_th15_cause: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.alarm[ALM_15_BASE] |-> $past(pm.cur15[PM_UAS] > s_q.th15[PM_UAS]))
    else $error("15-minute alarm without count above threshold");

  chk_th15_legal: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.th15[PM_UAS] <= TH15_MAX && s_q.th15[PM_ES] <= TH15_MAX)
    else $error("15-minute threshold out of range");

  chk_thday_legal: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.thday[PM_SES] <= THDAY_MAX) else $error("day threshold out of range");

  chk_margin_off: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.th_snr == 0 ##1 s_q.th_snr == 0 |-> !s_q.alarm[ALM_MARGIN])
    else $error("margin alarm while supervision off");

  chk_attn_off: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.th_attn == 0 ##1 s_q.th_attn == 0 |-> !s_q.alarm[ALM_ATTN])
    else $error("attenuation alarm while supervision off");

  chk_commit_only: assert property (@(posedge sys_clk) disable iff (srst)
    !commit_wr |=> $stable(s_q.th15) && $stable(s_q.thday) && $stable(s_q.th_snr))
    else $error("threshold changed without commit");

  chk_cnt_step: assert property (@(posedge sys_clk) disable iff (srst)
    rise[0] && !clr_cmd |=> s_q.cnt[0] == $past(s_q.cnt[0]) + 1)
    else $error("occurrence count not advanced");

  chk_cnt_clear: assert property (@(posedge sys_clk) disable iff (srst)
    clr_cmd && !rise[1] |=> s_q.cnt[1] == 0) else $error("counter not cleared");

  chk_log_single: assert property (@(posedge sys_clk) disable iff (srst)
    hist_push |=> $countones(s_q.logged ^ $past(s_q.logged)) == 1)
    else $error("history logged other than one event");

  chk_pmh_grow: assert property (@(posedge sys_clk) disable iff (srst)
    interval_end && s_q.pmh_cnt < PMH_FULL |=> s_q.pmh_cnt == $past(s_q.pmh_cnt) + 1)
    else $error("interval record not kept");

  chk_state_read: assert property (@(posedge sys_clk) disable iff (srst)
    req.rd && req.addr == REG_STATE |=> rdata == DATA_W'($past(s_q.alarm)))
    else $error("state report mismatch");

  chk_margin_raise: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.th_snr != '0 && pm.margin < MEAS_W'(s_q.th_snr) |=> s_q.alarm[ALM_MARGIN])
    else $error("margin alarm not raised");

  chk_attn_raise: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.th_attn != '0 && pm.attenuation > MEAS_W'(s_q.th_attn) |=> s_q.alarm[ALM_ATTN])
    else $error("attenuation alarm not raised");

  chk_day_raise: assert property (@(posedge sys_clk) disable iff (srst)
    pm.day[PM_UAS] > s_q.thday[PM_UAS] |=> s_q.alarm[ALM_DAY_BASE + PM_UAS])
    else $error("day alarm not raised");

  chk_line_raise: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.line_sync.line_signal_loss_alarm |=> s_q.alarm[ALM_LINE_LOSS])
    else $error("line loss not reported");

  chk_term_raise: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.line_sync.terminal_port_signal_loss_alarm |=> s_q.alarm[ALM_TERM_LOSS])
    else $error("terminal loss not reported");

  chk_abandon_keep: assert property (@(posedge sys_clk) disable iff (srst)
    commit_wr && req.wdata[COMMIT_ABANDON_BIT] |=> s_q.edit == '0 && $stable(s_q.th15) &&
    $stable(s_q.thday) && $stable(s_q.th_snr) && $stable(s_q.th_attn))
    else $error("abandoned edit changed a threshold");

  chk_cnt_zero: assert property (@(posedge sys_clk) disable iff (srst)
    clr_cmd && rise == '0 |=> s_q.cnt == '0) else $error("counters not all cleared");

  chk_ses_off: assert property (@(posedge sys_clk) disable iff (srst)
    s_q.th15[PM_SES] == '0 |=> !s_q.alarm[ALM_15_BASE + PM_SES])
    else $error("disabled 15-minute alarm raised");
endmodule

// ### inc/dam_pkg.sv
package dam_pkg;
  // Alarm table layout
  localparam int unsigned ALARM_NUM = 11;
  localparam int unsigned ALARM_IDX_W = 4;
  localparam logic [3:0] ALM_LINE_LOSS = 4'h0;
  localparam logic [3:0] ALM_SYNC_LOSS = 4'h1;
  localparam logic [3:0] ALM_MARGIN = 4'h2;
  localparam logic [3:0] ALM_ATTN = 4'h3;
  localparam int unsigned ALM_15_BASE = 4;
  localparam int unsigned ALM_DAY_BASE = 7;
  localparam logic [3:0] ALM_TERM_LOSS = 4'ha;
  // Count kinds inside each interval group
  localparam int unsigned PM_KINDS = 3;
  localparam int unsigned PM_UAS = 0;
  localparam int unsigned PM_SES = 1;
  localparam int unsigned PM_ES = 2;
  // Value widths and limits
  localparam int unsigned TH15_W = 10;
  localparam int unsigned THDAY_W = 17;
  localparam int unsigned SNR_W = 4;
  localparam int unsigned ATTN_W = 7;
  localparam int unsigned MEAS_W = 8;
  localparam int unsigned EDIT_W = 17;
  localparam logic [9:0] TH15_MAX = 10'h384;
  localparam logic [16:0] THDAY_MAX = 17'h1_5180;
  localparam logic [16:0] TH_RESET = 17'h0_0000;
  // Stores
  localparam int unsigned HIST_DEPTH = 64;
  localparam int unsigned HIST_PTR_W = 6;
  localparam int unsigned HIST_CNT_W = 7;
  localparam logic [6:0] HIST_FULL = 7'h40;
  localparam int unsigned PMH_DEPTH = 96;
  localparam int unsigned PMH_PTR_W = 7;
  localparam logic [6:0] PMH_LAST = 7'h5f;
  localparam logic [6:0] PMH_FULL = 7'h60;
  localparam int unsigned PMH_ENT_W = PM_KINDS * TH15_W;
  localparam int unsigned STAMP_W = 32;
  // Register bus
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TH15_UAS = 8'h04;
  localparam logic [7:0] REG_TH15_SES = 8'h08;
  localparam logic [7:0] REG_TH15_ES = 8'h0c;
  localparam logic [7:0] REG_THDAY_UAS = 8'h10;
  localparam logic [7:0] REG_THDAY_SES = 8'h14;
  localparam logic [7:0] REG_THDAY_ES = 8'h18;
  localparam logic [7:0] REG_TH_SNR = 8'h1c;
  localparam logic [7:0] REG_TH_ATTN = 8'h20;
  localparam logic [7:0] REG_EDIT = 8'h24;
  localparam logic [7:0] REG_COMMIT = 8'h28;
  localparam logic [7:0] REG_STATE = 8'h2c;
  localparam logic [7:0] REG_CNT_SEL = 8'h30;
  localparam logic [7:0] REG_CNT_DATA = 8'h34;
  localparam logic [7:0] REG_HIST_SEL = 8'h38;
  localparam logic [7:0] REG_HIST_INFO = 8'h3c;
  localparam logic [7:0] REG_HIST_STAMP = 8'h40;
  localparam logic [7:0] REG_HIST_COUNT = 8'h44;
  localparam logic [7:0] REG_IRQ_STAT = 8'h48;
  localparam logic [7:0] REG_IRQ_CLR = 8'h4c;
  localparam logic [7:0] REG_IRQ_EN = 8'h50;
  localparam logic [7:0] REG_PMH_SEL = 8'h54;
  localparam logic [7:0] REG_PMH_DATA = 8'h58;
  localparam logic [7:0] REG_PMH_COUNT = 8'h5c;
  // Register fields
  localparam int unsigned CTRL_CLEAR_BIT = 0;
  localparam int unsigned COMMIT_TGT_W = 3;
  localparam int unsigned COMMIT_ABANDON_BIT = 8;
  localparam logic [2:0] TGT_15_UAS = 3'h0;
  localparam logic [2:0] TGT_15_SES = 3'h1;
  localparam logic [2:0] TGT_15_ES = 3'h2;
  localparam logic [2:0] TGT_DAY_UAS = 3'h3;
  localparam logic [2:0] TGT_DAY_SES = 3'h4;
  localparam logic [2:0] TGT_DAY_ES = 3'h5;
  localparam logic [2:0] TGT_SNR = 3'h6;
  localparam logic [2:0] TGT_ATTN = 3'h7;
  localparam int unsigned HIST_RAISED_BIT = 8;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_RAISE = 0;
  localparam int unsigned IRQ_FALL = 1;
  localparam int unsigned IRQ_WRAP = 2;
  localparam int unsigned IRQ_INTERVAL = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } dam_req_type;

  typedef struct packed {
    logic [PM_KINDS-1:0][TH15_W-1:0] cur15;
    logic [PM_KINDS-1:0][THDAY_W-1:0] day;
    logic [MEAS_W-1:0] margin;
    logic [MEAS_W-1:0] attenuation;
  } dam_pm_type;

  typedef struct packed {
    logic line_signal_loss_alarm;
    logic line_sync_word_loss_alarm;
    logic terminal_port_signal_loss_alarm;
  } dam_line_type;

  typedef struct packed {
    logic [ALARM_IDX_W-1:0] alarm;
    logic raised;
    logic [STAMP_W-1:0] stamp;
  } dam_hist_ent_type;
endpackage

// ### rtl/dam_history.sv
`timescale 1ns/10ps
module dam_history (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic push,
  input wire dam_pkg::dam_hist_ent_type ent,
  input wire logic clear,
  input wire logic [dam_pkg::HIST_PTR_W-1:0] rd_idx,
  output dam_pkg::dam_hist_ent_type rd_ent,
  output logic [dam_pkg::HIST_CNT_W-1:0] count,
  output logic wrap
);
  import dam_pkg::*;

  typedef struct packed {
    dam_hist_ent_type [HIST_DEPTH-1:0] mem;
    logic [HIST_PTR_W-1:0] wp;
    logic [HIST_CNT_W-1:0] cnt;
  } dam_hist_state_type;

  dam_hist_state_type h_q;
  dam_hist_state_type h_d;
  logic full;

  // Ring store; a push in the clear cycle survives as the first entry
  always_comb begin
    logic [HIST_PTR_W-1:0] wp_e;
    logic [HIST_CNT_W-1:0] cnt_e;
    wp_e = h_q.wp;
    cnt_e = h_q.cnt;
    h_d = h_q;
    full = (h_q.cnt == HIST_FULL);
    wrap = push && full && !clear;
    if (clear) begin
      wp_e = '0;
      cnt_e = '0;
    end
    h_d.wp = wp_e;
    h_d.cnt = cnt_e;
    if (push) begin
      h_d.mem[wp_e] = ent;
      h_d.wp = wp_e + HIST_PTR_W'(1);
      if (cnt_e != HIST_FULL) begin
        h_d.cnt = cnt_e + HIST_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      h_q <= '0;
    end else begin
      h_q <= h_d;
    end
  end

  // Index 0 is the oldest retained event; the 6-bit sum wraps by itself
  assign rd_ent = h_q.mem[(full ? h_q.wp : HIST_PTR_W'(0)) + rd_idx];
  assign count = h_q.cnt;

  chk_hist_bound: assert property (@(posedge sys_clk) disable iff (srst)
    h_q.cnt <= HIST_FULL) else $error("history count above depth");

  chk_hist_grow: assert property (@(posedge sys_clk) disable iff (srst)
    push && !clear && !full |=> h_q.cnt == $past(h_q.cnt) + 1)
    else $error("history push not counted");

  chk_hist_clear: assert property (@(posedge sys_clk) disable iff (srst)
    clear && !push |=> h_q.cnt == 0) else $error("history not emptied");

  chk_hist_keep: assert property (@(posedge sys_clk) disable iff (srst)
    push && !clear && full |=> h_q.cnt == HIST_FULL &&
    h_q.wp == HIST_PTR_W'($past(h_q.wp) + 1))
    else $error("full history did not overwrite oldest");
endmodule

// ### bench/dam_monitor_tb.sv
`timescale 1ns/10ps
module dam_monitor_tb;
  import dam_pkg::*;
  logic sys_clk;
  logic srst;
  dam_req_type req;
  logic [DATA_W-1:0] rdata;
  dam_pm_type pm;
  dam_line_type line_raw;
  logic interval_end;
  logic [STAMP_W-1:0] stamp;
  logic irq;
  int error_cnt;
  int num_checks;
  logic [31:0] s0;
  logic [31:0] s1;

  dam_monitor #(.CNT_W(16)) i_dut (
    .sys_clk(sys_clk),
    .srst(srst),
    .req(req),
    .rdata(rdata),
    .pm(pm),
    .line_raw(line_raw),
    .interval_end(interval_end),
    .stamp(stamp),
    .irq(irq)
  );

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  // Free-running timestamp so history order shows in the stamps
  always @(posedge sys_clk) begin
    stamp <= stamp + 32'h0000_0001;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] d;
    rd(a, d);
    chk(name, d, exp);
  endtask

  // Stage a value and commit it, or abandon the edit
  task automatic cm(input logic [2:0] t, input logic [31:0] v, input logic ab);
    wr(REG_EDIT, v);
    wr(REG_COMMIT, {23'h00_0000, ab, 5'h00, t});
  endtask

  function automatic logic [31:0] th_max(input int t);
    return t < 3 ? 32'h0000_0384 : t < 6 ? 32'h0001_5180 : t == 6 ? 32'h0000_000f : 32'h0000_007f;
  endfunction

  task automatic t_reset;
    for (int t = 0; t < 8; t++) begin
      rdchk(8'h04 + 8'(t * 4), 32'h0000_0000, "thr reset");
    end
    rdchk(REG_STATE, 32'h0000_0000, "state reset");
    rdchk(REG_HIST_COUNT, 32'h0000_0000, "hist reset");
    rdchk(8'hfc, 32'h0000_0000, "unmapped");
    rdchk(REG_PMH_DATA, 32'h0000_0000, "pmh empty");
    $display("test reset done");
  endtask

  // Upper limit accepted, one past it refused, abandon keeps the old value
  task automatic t_limits;
    for (int t = 0; t < 8; t++) begin
      cm(3'(t), th_max(t), 1'b0);
      rdchk(8'h04 + 8'(t * 4), th_max(t), "thr max");
      cm(3'(t), th_max(t) + 32'h0000_0001, 1'b0);
      rdchk(8'h04 + 8'(t * 4), th_max(t), "thr over");
      cm(3'(t), 32'h0000_0001, 1'b1);
      rdchk(8'h04 + 8'(t * 4), th_max(t), "thr abandon");
      rdchk(REG_EDIT, 32'h0000_0000, "edit abandon");
      cm(3'(t), 32'h0000_0000, 1'b0);
    end
    $display("test limits done");
  endtask

  task automatic t_alarm;
    cm(TGT_15_UAS, 32'h0000_0003, 1'b0);
    repeat (4) @(posedge sys_clk);
    wr(REG_CTRL, 32'h0000_0001);
    wr(REG_IRQ_CLR, 32'h0000_000f);
    wr(REG_IRQ_EN, 32'h0000_0001);
    pm.cur15[PM_UAS] <= 10'h003;
    repeat (3) @(posedge sys_clk);
    rdchk(REG_STATE, 32'h0000_0000, "equal no alarm");
    pm.cur15[PM_UAS] <= 10'h004;
    repeat (3) @(posedge sys_clk);
    rdchk(REG_STATE, 32'h0000_0010, "above alarm");
    @(posedge sys_clk);
    #1;
    chk("rdata drop", rdata, 32'h0000_0000);
    wr(REG_CNT_SEL, 32'h0000_0004);
    rdchk(REG_CNT_SEL, 32'h0000_0004, "cnt sel");
    rdchk(REG_CNT_DATA, 32'h0000_0001, "occur count");
    rdchk(REG_HIST_COUNT, 32'h0000_0001, "hist one");
    rdchk(REG_HIST_INFO, 32'h0000_0104, "hist raised");
    rd(REG_HIST_STAMP, s0);
    chk("irq on", irq, 1'b1);
    wr(REG_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge sys_clk);
    chk("irq masked", irq, 1'b0);
    wr(REG_IRQ_CLR, 32'h0000_0001);
    wr(REG_IRQ_EN, 32'h0000_0001);
    rdchk(REG_IRQ_EN, 32'h0000_0001, "irq en");
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", irq, 1'b0);
    pm.cur15[PM_UAS] <= 10'h000;
    repeat (3) @(posedge sys_clk);
    rdchk(REG_HIST_COUNT, 32'h0000_0002, "hist two");
    wr(REG_HIST_SEL, 32'h0000_0001);
    rdchk(REG_HIST_INFO, 32'h0000_0004, "hist cleared");
    rd(REG_HIST_STAMP, s1);
    chk("stamp order", 32'(s1 > s0), 32'h0000_0001);
    $display("test alarm done");
  endtask

  // Sixty-six events into a store of sixty-four
  task automatic t_full;
    wr(REG_CTRL, 32'h0000_0001);
    for (int i = 0; i < 66; i++) begin
      pm.cur15[PM_UAS] <= (i % 2 == 0) ? 10'h004 : 10'h000;
      repeat (3) @(posedge sys_clk);
    end
    rdchk(REG_HIST_COUNT, 32'h0000_0040, "hist full");
    rdchk(REG_IRQ_STAT, 32'h0000_0007, "wrap stat");
    wr(REG_HIST_SEL, 32'h0000_0000);
    rdchk(REG_HIST_INFO, 32'h0000_0104, "oldest kept");
    wr(REG_HIST_SEL, 32'h0000_003f);
    rdchk(REG_HIST_SEL, 32'h0000_003f, "hist sel");
    rdchk(REG_HIST_INFO, 32'h0000_0004, "newest");
    rdchk(REG_CNT_DATA, 32'h0000_0021, "count 33");
    wr(REG_CTRL, 32'h0000_0001);
    rdchk(REG_HIST_COUNT, 32'h0000_0000, "clear hist");
    rdchk(REG_CNT_DATA, 32'h0000_0000, "clear cnt");
    $display("test full done");
  endtask

  // Boundaries of the margin, attenuation and day comparisons
  task automatic t_meas;
    pm.margin <= 8'h09;
    cm(TGT_SNR, 32'h0000_0005, 1'b0);
    cm(TGT_ATTN, 32'h0000_000a, 1'b0);
    cm(TGT_DAY_UAS, 32'h0000_0001, 1'b0);
    pm.margin <= 8'h04;
    pm.attenuation <= 8'h0b;
    pm.day[PM_UAS] <= 17'h0_0002;
    repeat (3) @(posedge sys_clk);
    rdchk(REG_STATE, 32'h0000_008c, "meas alarm");
    pm.margin <= 8'h05;
    pm.attenuation <= 8'h0a;
    pm.day[PM_UAS] <= 17'h0_0001;
    repeat (3) @(posedge sys_clk);
    rdchk(REG_STATE, 32'h0000_0000, "meas edge");
    line_raw <= '1;
    repeat (6) @(posedge sys_clk);
    rdchk(REG_STATE, 32'h0000_0403, "line alarms");
    line_raw <= '0;
    repeat (6) @(posedge sys_clk);
    rdchk(REG_STATE, 32'h0000_0000, "line ok");
    $display("test meas done");
  endtask

  task automatic t_pmh;
    pm.cur15 <= {10'h003, 10'h002, 10'h001};
    for (int i = 0; i < 97; i++) begin
      @(posedge sys_clk);
      interval_end <= 1'b1;
      @(posedge sys_clk);
      interval_end <= 1'b0;
      if (i == 0) begin
        rdchk(REG_PMH_COUNT, 32'h0000_0001, "pmh one");
        wr(REG_PMH_SEL, 32'h0000_0000);
        rdchk(REG_PMH_DATA, 32'h0030_0801, "pmh data");
        rdchk(REG_STATE, 32'h0000_0000, "zero disables");
        pm.cur15 <= '0;
      end
    end
    rdchk(REG_PMH_COUNT, 32'h0000_0060, "pmh full");
    rdchk(REG_IRQ_STAT, 32'h0000_000f, "interval stat");
    $display("test pmh done");
  endtask

  // Watchdog so that no hang goes unreported
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    $display("BAD watchdog expected finish seen hang");
    end_sim();
  end

  initial begin
    sys_clk = 1'b0;
    srst = 1'b1;
    req = '0;
    pm = '0;
    line_raw = '0;
    interval_end = 1'b0;
    stamp = '0;
    error_cnt = 0;
    num_checks = 0;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_limits();
    t_alarm();
    t_full();
    t_meas();
    t_pmh();
    end_sim();
  end
endmodule
